/* File: core/ipec_ctrl.sv */
// Interrupt control slice: control, flag, priority and event registers on AHB-Lite.
// Assumes one clock MCLK, synchronous reset SRST, and request inputs on MCLK.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ipec_ctrl (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [ipec_pkg::IPEC_NUM_EXT-1:0] EXT_IRQ_PIN,
    input wire logic CMP_IRQ_REQ,
    input wire logic I2C_ONE_MASTER_REQ,
    input wire logic I2C_ONE_SLAVE_REQ,
    input wire logic [ipec_pkg::IPEC_NUM_SRC-1:0] SRC_REQ,
    input wire logic IRQ_DISABLE_INSTR_ACTIVE,
    output logic ALT_VECTOR_TABLE_SELECT,
    output logic [2:0] CORE_REQ_LEVEL,
    output logic [3:0] CORE_REQ_SOURCE,
    output logic IRQ
);
    import ipec_pkg::*;

    // Pick the 3-bit priority field of one slot from a priority register
    function automatic logic [2:0] prio_slot(input logic [15:0] regval, input int slot);
        prio_slot = regval[slot*IPEC_PRIO_SLOT_W +: 3];
    endfunction

    // Implemented-bit mask for a register offset; unmapped reads as zero
    function automatic logic [15:0] rd_mask_of(input logic [7:0] off);
        logic [15:0] m;
        m = 16'h0000;
        unique case (off)
            IPEC_OFF_CTL: m = IPEC_CTL_RD_MASK;
            IPEC_OFF_FLAG: m = IPEC_FLAG_MASK;
            IPEC_OFF_PRIO_A: m = IPEC_PRIO_A_MASK;
            IPEC_OFF_PRIO_B: m = IPEC_PRIO_B_MASK;
            IPEC_OFF_PRIO_C: m = IPEC_PRIO_C_MASK;
            IPEC_OFF_EVT_STAT: m = IPEC_EVT_MASK;
            IPEC_OFF_EVT_MASK: m = IPEC_EVT_MASK;
            default: m = 16'h0000;
        endcase
        rd_mask_of = m;
    endfunction

    ipec_bus_state_type state_ff;
    ipec_bus_state_type nxt_state;
    logic [7:0] addr_ff;
    logic write_ff;
    logic ready_ff;
    logic [31:0] rdata_ff;
    logic [15:0] ctl_ff;
    logic [15:0] nxt_ctl;
    logic [15:0] flag_ff;
    logic [15:0] nxt_flag;
    logic [15:0] prio_a_ff;
    logic [15:0] prio_b_ff;
    logic [15:0] prio_c_ff;
    logic [15:0] evt_stat_ff;
    logic [15:0] nxt_evt_stat;
    logic [15:0] evt_mask_ff;
    logic irq_ff;
    logic [2:0] lvl_ff;
    logic [3:0] src_ff;
    logic [2:0] nxt_lvl;
    logic [3:0] nxt_src;
    logic [IPEC_NUM_EXT-1:0] ext_edge;
    logic [2:0] prio_all [IPEC_NUM_SRC];

    // Address phase acceptance and the one access cycle that follows
    wire accept = HSEL & HTRANS[1] & HREADY;
    wire do_acc = (state_ff == IPEC_ST_ACCESS);
    wire wr_do = do_acc & write_ff;
    wire rd_do = do_acc & ~write_ff;
    wire [15:0] wdata = HWDATA[15:0];
    wire wr_ctl = wr_do & (addr_ff == IPEC_OFF_CTL);
    wire wr_flag = wr_do & (addr_ff == IPEC_OFF_FLAG);
    wire wr_pa = wr_do & (addr_ff == IPEC_OFF_PRIO_A);
    wire wr_pb = wr_do & (addr_ff == IPEC_OFF_PRIO_B);
    wire wr_pc = wr_do & (addr_ff == IPEC_OFF_PRIO_C);
    wire wr_es = wr_do & (addr_ff == IPEC_OFF_EVT_STAT);
    wire wr_em = wr_do & (addr_ff == IPEC_OFF_EVT_MASK);
    wire [15:0] rd_mask = rd_mask_of(addr_ff);

    // Live view of control: disable-instruction status comes from the core
    wire [15:0] ctl_view = (ctl_ff & IPEC_CTL_WR_MASK)
        | ({15'h0000, IRQ_DISABLE_INSTR_ACTIVE} << IPEC_CTL_IRQ_DISABLE_INSTR_ACTIVE_BIT);

    // Read mux; masking forces every unimplemented bit to zero
    wire [15:0] rd_raw = (addr_ff == IPEC_OFF_CTL) ? ctl_view :
        (addr_ff == IPEC_OFF_FLAG) ? flag_ff :
        (addr_ff == IPEC_OFF_PRIO_A) ? prio_a_ff :
        (addr_ff == IPEC_OFF_PRIO_B) ? prio_b_ff :
        (addr_ff == IPEC_OFF_PRIO_C) ? prio_c_ff :
        (addr_ff == IPEC_OFF_EVT_STAT) ? evt_stat_ff :
        (addr_ff == IPEC_OFF_EVT_MASK) ? evt_mask_ff : 16'h0000;
    wire [31:0] rd_word = {16'h0000, rd_raw & rd_mask};

    // Sequencer: one wait state so a read never races the write before it
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            IPEC_ST_IDLE: nxt_state = accept ? IPEC_ST_ACCESS : IPEC_ST_IDLE;
            IPEC_ST_ACCESS: nxt_state = IPEC_ST_DONE;
            IPEC_ST_DONE: nxt_state = accept ? IPEC_ST_ACCESS : IPEC_ST_IDLE;
            default: nxt_state = IPEC_ST_IDLE;
        endcase
    end

    // Bus-side registers
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state_ff <= IPEC_ST_IDLE;
            addr_ff <= 8'h00;
            write_ff <= 1'b0;
            ready_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state != IPEC_ST_ACCESS);
            if (accept) begin
                addr_ff <= HADDR[7:0];
                write_ff <= HWRITE;
            end
            if (rd_do) begin
                rdata_ff <= rd_word;
            end
        end
    end
    assign HRDATA = rdata_ff;
    assign HREADYOUT = ready_ff;
    assign HRESP = 1'b0;

    // Control: only vector select and edge selects are writable
    assign nxt_ctl = wr_ctl ? (wdata & IPEC_CTL_WR_MASK) : ctl_ff;

    // Flags: hardware set wins over a software write in the same cycle
    assign nxt_flag = ((wr_flag ? wdata : flag_ff)
        | ({13'h0000, CMP_IRQ_REQ, 2'b00})
        | ({14'h0000, I2C_ONE_MASTER_REQ, 1'b0})
        | ({15'h0000, I2C_ONE_SLAVE_REQ})) & IPEC_FLAG_MASK;

    // Event status: edges and flag sources, write one to clear, set wins
    wire [15:0] evt_set = {10'h000, CMP_IRQ_REQ, I2C_ONE_MASTER_REQ, I2C_ONE_SLAVE_REQ,
        ext_edge};
    wire [15:0] evt_clr = wr_es ? wdata : 16'h0000;
    assign nxt_evt_stat = ((evt_stat_ff & ~evt_clr) | evt_set) & IPEC_EVT_MASK;

    // Software-visible registers
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ctl_ff <= IPEC_CTL_RST;
            flag_ff <= IPEC_FLAG_RST;
            prio_a_ff <= IPEC_PRIO_A_RST;
            prio_b_ff <= IPEC_PRIO_B_RST;
            prio_c_ff <= IPEC_PRIO_C_RST;
            evt_stat_ff <= IPEC_EVT_RST;
            evt_mask_ff <= IPEC_EVT_RST;
        end else begin
            ctl_ff <= nxt_ctl;
            flag_ff <= nxt_flag;
            evt_stat_ff <= nxt_evt_stat;
            if (wr_pa) begin
                prio_a_ff <= wdata & IPEC_PRIO_A_MASK;
            end
            if (wr_pb) begin
                prio_b_ff <= wdata & IPEC_PRIO_B_MASK;
            end
            if (wr_pc) begin
                prio_c_ff <= wdata & IPEC_PRIO_C_MASK;
            end
            if (wr_em) begin
                evt_mask_ff <= wdata & IPEC_EVT_MASK;
            end
        end
    end
    assign ALT_VECTOR_TABLE_SELECT = ctl_ff[IPEC_CTL_ALT_BIT];

    // External pins: synchronised, then edge detected per polarity
    ipec_edge_det u_edge (
        .mclk(MCLK),
        .srst(SRST),
        .pin_in(EXT_IRQ_PIN),
        .pol_falling(ctl_ff[IPEC_NUM_EXT-1:0]),
        .edge_pulse(ext_edge)
    );

    // Source order: DMA0, IC2, OC2, T2, UART1 TX, ADC1, DMA1, T5, INT2, UART2 RX, UART2 TX
    assign prio_all[0] = prio_slot(prio_a_ff, 0);
    assign prio_all[1] = prio_slot(prio_a_ff, 1);
    assign prio_all[2] = prio_slot(prio_a_ff, 2);
    assign prio_all[3] = prio_slot(prio_a_ff, 3);
    assign prio_all[4] = prio_slot(prio_b_ff, 0);
    assign prio_all[5] = prio_slot(prio_b_ff, 1);
    assign prio_all[6] = prio_slot(prio_b_ff, 2);
    assign prio_all[7] = prio_slot(prio_c_ff, 0);
    assign prio_all[8] = prio_slot(prio_c_ff, 1);
    assign prio_all[9] = prio_slot(prio_c_ff, 2);
    assign prio_all[10] = prio_slot(prio_c_ff, 3);

    // Highest level wins; on a tie the lower source index is kept
    always_comb begin
        nxt_lvl = IPEC_PRIO_OFF;
        nxt_src = 4'h0;
        for (int i = 0; i < IPEC_NUM_SRC; i++) begin
            if (SRC_REQ[i] && (prio_all[i] > nxt_lvl)) begin
                nxt_lvl = prio_all[i];
                nxt_src = 4'(i);
            end
        end
    end

    // Registered core request and interrupt line
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            lvl_ff <= IPEC_PRIO_OFF;
            src_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
            src_ff <= nxt_src;
            irq_ff <= |(evt_stat_ff & evt_mask_ff);
        end
    end
    assign CORE_REQ_LEVEL = lvl_ff;
    assign CORE_REQ_SOURCE = src_ff;
    assign IRQ = irq_ff;

    a_ctl_reset_clear: assert property (
        @(posedge MCLK) disable iff (SRST)
        $fell(SRST) |-> (ctl_ff == IPEC_CTL_RST) && !ALT_VECTOR_TABLE_SELECT)
        else $error("control not cleared after reset");
    a_cmp_flag_set: assert property (
        @(posedge MCLK) disable iff (SRST)
        CMP_IRQ_REQ |=> flag_ff[IPEC_FLAG_CMP_BIT])
        else $error("comparator flag not set");
    a_i2cm_flag_set: assert property (
        @(posedge MCLK) disable iff (SRST)
        I2C_ONE_MASTER_REQ |=> flag_ff[IPEC_FLAG_I2CM_BIT])
        else $error("i2c master flag not set");
    a_i2cs_flag_set: assert property (
        @(posedge MCLK) disable iff (SRST)
        I2C_ONE_SLAVE_REQ |=> flag_ff[IPEC_FLAG_I2CS_BIT])
        else $error("i2c slave flag not set");
    a_flag_no_request: assert property (
        @(posedge MCLK) disable iff (SRST)
        (!flag_ff[IPEC_FLAG_CMP_BIT] && !CMP_IRQ_REQ && !wr_flag)
            |=> !flag_ff[IPEC_FLAG_CMP_BIT])
        else $error("comparator flag set without a request");
    a_prio_disabled: assert property (
        @(posedge MCLK) disable iff (SRST)
        (SRC_REQ[0] && (prio_all[0] == IPEC_PRIO_OFF) && (SRC_REQ[IPEC_NUM_SRC-1:1] == '0))
            |=> (CORE_REQ_LEVEL == IPEC_PRIO_OFF))
        else $error("disabled source reached the core");
    a_dma0_field_write: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_pa |=> (prio_a_ff[2:0] == $past(HWDATA[2:0])))
        else $error("dma zero priority field not written");
    a_unused_read_zero: assert property (
        @(posedge MCLK) disable iff (SRST)
        rd_do |=> ((HRDATA & ~{16'h0000, $past(rd_mask)}) == 32'h00000000) && HREADYOUT)
        else $error("unimplemented bits read non-zero");
    a_alt_vector_write: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_ctl |=> (ALT_VECTOR_TABLE_SELECT == $past(HWDATA[15])))
        else $error("vector table select not updated");
    a_irq_disable_instr_active_status_read: assert property (
        @(posedge MCLK) disable iff (SRST)
        (rd_do && (addr_ff == IPEC_OFF_CTL))
            |=> (HRDATA[IPEC_CTL_IRQ_DISABLE_INSTR_ACTIVE_BIT] == $past(IRQ_DISABLE_INSTR_ACTIVE)))
        else $error("disable status read wrong");
    a_irq_follows_stat: assert property (
        @(posedge MCLK) disable iff (SRST)
        (|(evt_stat_ff & evt_mask_ff)) |=> IRQ)
        else $error("interrupt line not raised");

    // Bus timing, idle arbitration, clears and the falling interrupt line
    a_ready_one_wait: assert property (
        @(posedge MCLK) disable iff (SRST)
        accept |=> !HREADYOUT ##1 HREADYOUT)
        else $error("ready did not give exactly one wait state");
    a_no_req_idle: assert property (
        @(posedge MCLK) disable iff (SRST)
        (SRC_REQ == '0) |=> (CORE_REQ_LEVEL == IPEC_PRIO_OFF))
        else $error("core request level without any source request");
    a_evt_clear_bit: assert property (
        @(posedge MCLK) disable iff (SRST)
        (wr_es && wdata[0] && !ext_edge[0])
            |=> !evt_stat_ff[0])
        else $error("event status bit not cleared by a one");
    a_flag_write_zero: assert property (
        @(posedge MCLK) disable iff (SRST)
        (wr_flag && !wdata[IPEC_FLAG_CMP_BIT] && !CMP_IRQ_REQ)
            |=> !flag_ff[IPEC_FLAG_CMP_BIT])
        else $error("comparator flag kept after a zero write");
    a_irq_drops: assert property (
        @(posedge MCLK) disable iff (SRST)
        (!(|(evt_stat_ff & evt_mask_ff))) |=> !IRQ)
        else $error("interrupt line high with nothing pending");

endmodule

/* File: core/ipec_edge_det.sv */
// Pin synchroniser and polarity-selectable edge detector for external inputs.
// Assumes the pins are asynchronous to mclk; output pulses last one cycle.
`timescale 1ns/1ps
module ipec_edge_det (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [ipec_pkg::IPEC_NUM_EXT-1:0] pin_in,
    input wire logic [ipec_pkg::IPEC_NUM_EXT-1:0] pol_falling,
    output logic [ipec_pkg::IPEC_NUM_EXT-1:0] edge_pulse
);
    import ipec_pkg::*;

    genvar gi;
    generate
        for (gi = 0; gi < IPEC_NUM_EXT; gi++) begin : g_pin
            logic meta_ff;
            logic sync_ff;
            logic prev_ff;
            logic pulse_ff;
            logic hit;

            // Falling edge when the select is one, rising when zero
            assign hit = pol_falling[gi] ? (prev_ff & ~sync_ff) : (~prev_ff & sync_ff);

            // Only sync_ff reads the first stage
            always_ff @(posedge mclk) begin
                if (srst) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    prev_ff <= 1'b0;
                    pulse_ff <= 1'b0;
                end else begin
                    meta_ff <= pin_in[gi];
                    sync_ff <= meta_ff;
                    prev_ff <= sync_ff;
                    pulse_ff <= hit;
                end
            end
            assign edge_pulse[gi] = pulse_ff;

            a_rise_edge_seen: assert property (
                @(posedge mclk) disable iff (srst)
                (!pol_falling[gi] && !prev_ff && sync_ff) |=> pulse_ff)
                else $error("rising edge missed with rising polarity");
            a_fall_edge_seen: assert property (
                @(posedge mclk) disable iff (srst)
                (pol_falling[gi] && prev_ff && !sync_ff) |=> pulse_ff)
                else $error("falling edge missed with falling polarity");
        end
    endgenerate

endmodule

/* File: core/ipec_pkg.sv */
// Constants, offsets, reset values and types for the interrupt control slice.
// Assumes a single 20 MHz clock domain and an AHB-Lite register port.
// Notes on behaviour
// - Edge select one falling, zero rising.
// - Three edge select bits, cleared at reset.
// - Comparator request sets flag bit 2.
// - I2C one master request sets bit 1.
// - I2C one slave request sets bit 0.
// - Flag reads one once requested, else zero.
// - Priority 1..7, seven highest, zero disables.
// - DMA zero priority in bits 2..0.
// - Unused bits ignore writes, read zero.
package ipec_pkg;

    // Register byte offsets inside the slave window
    localparam logic [7:0] IPEC_OFF_CTL = 8'h00;
    localparam logic [7:0] IPEC_OFF_FLAG = 8'h04;
    localparam logic [7:0] IPEC_OFF_PRIO_A = 8'h08;
    localparam logic [7:0] IPEC_OFF_PRIO_B = 8'h0C;
    localparam logic [7:0] IPEC_OFF_PRIO_C = 8'h10;
    localparam logic [7:0] IPEC_OFF_EVT_STAT = 8'h14;
    localparam logic [7:0] IPEC_OFF_EVT_MASK = 8'h18;

    // Implemented bit masks per register
    localparam logic [15:0] IPEC_CTL_WR_MASK = 16'h8007;
    localparam logic [15:0] IPEC_CTL_RD_MASK = 16'hC007;
    localparam logic [15:0] IPEC_FLAG_MASK = 16'h0007;
    localparam logic [15:0] IPEC_PRIO_A_MASK = 16'h7777;
    localparam logic [15:0] IPEC_PRIO_B_MASK = 16'h0777;
    localparam logic [15:0] IPEC_PRIO_C_MASK = 16'h7777;
    localparam logic [15:0] IPEC_EVT_MASK = 16'h003F;

    // Values after reset
    localparam logic [15:0] IPEC_CTL_RST = 16'h0000;
    localparam logic [15:0] IPEC_FLAG_RST = 16'h0000;
    localparam logic [15:0] IPEC_PRIO_A_RST = 16'h4444;
    localparam logic [15:0] IPEC_PRIO_B_RST = 16'h0444;
    localparam logic [15:0] IPEC_PRIO_C_RST = 16'h4444;
    localparam logic [15:0] IPEC_EVT_RST = 16'h0000;

    // Field positions
    localparam int IPEC_CTL_ALT_BIT = 15;
    localparam int IPEC_CTL_IRQ_DISABLE_INSTR_ACTIVE_BIT = 14;
    localparam int IPEC_FLAG_CMP_BIT = 2;
    localparam int IPEC_FLAG_I2CM_BIT = 1;
    localparam int IPEC_FLAG_I2CS_BIT = 0;
    localparam int IPEC_PRIO_SLOT_W = 4;

    // Counts
    localparam int IPEC_NUM_EXT = 3;
    localparam int IPEC_NUM_EVT = 6;
    localparam int IPEC_NUM_SRC = 11;
    localparam logic [2:0] IPEC_PRIO_OFF = 3'h0;

    // Bus access sequencer, one-hot
    typedef enum logic [2:0] {
        IPEC_ST_IDLE = 3'b001,
        IPEC_ST_ACCESS = 3'b010,
        IPEC_ST_DONE = 3'b100
    } ipec_bus_state_type;

endpackage

/* File: test/ipec_core_model.sv */
// Behavioural model of the processor core that consumes the prioritised requests.
// Assumes the same clock and synchronous reset as the interrupt control slice.
`timescale 1ns/1ps
module ipec_core_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic irq_disable_instr_active_cmd,
    input wire logic [2:0] req_level,
    input wire logic [3:0] req_source,
    input wire logic alt_sel,
    output logic irq_disable_active,
    output logic [4:0] taken_vector
);
    logic irq_disable_instr_active_ff;
    logic [4:0] vec_ff;

    // Disable instruction is a level held while commanded; vectoring waits it out
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_disable_instr_active_ff <= 1'b0;
            vec_ff <= 5'h00;
        end else begin
            irq_disable_instr_active_ff <= irq_disable_instr_active_cmd;
            if (req_level != 3'h0 && !irq_disable_instr_active_ff) begin
                vec_ff <= {alt_sel, req_source};
            end
        end
    end

    assign irq_disable_active = irq_disable_instr_active_ff;
    assign taken_vector = vec_ff;
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the interrupt control slice, driven over AHB-Lite.
// Assumes the package and design are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
module testbench;
    import ipec_pkg::*;
    logic mclk, srst, hsel, hwrite, cmp_req, i2cm_req, i2cs_req, irq_disable_instr_active_cmd;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] ext_pin, req_level;
    logic [10:0] src_req;
    logic [3:0] req_src;
    logic hreadyout, hresp, alt_sel, irq, irq_disable_instr_active_act;
    logic [4:0] taken;
    int fail_count, n_tests;

    ipec_ctrl i_dut (.MCLK(mclk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .EXT_IRQ_PIN(ext_pin), .CMP_IRQ_REQ(cmp_req),
        .I2C_ONE_MASTER_REQ(i2cm_req), .I2C_ONE_SLAVE_REQ(i2cs_req), .SRC_REQ(src_req),
        .IRQ_DISABLE_INSTR_ACTIVE(irq_disable_instr_active_act), .ALT_VECTOR_TABLE_SELECT(alt_sel),
        .CORE_REQ_LEVEL(req_level), .CORE_REQ_SOURCE(req_src), .IRQ(irq));

    ipec_core_model i_core (.mclk(mclk), .srst(srst), .irq_disable_instr_active_cmd(irq_disable_instr_active_cmd),
        .req_level(req_level), .req_source(req_src), .alt_sel(alt_sel),
        .irq_disable_active(irq_disable_instr_active_act), .taken_vector(taken));

    // Free-running 50 ns clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each phase holds until ready is seen high at a rising edge; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
        check("bus response", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        bus(1'b1, a, {16'h0000, d}, r);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [15:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(name, r, {16'h0000, exp});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic pulse(input logic [2:0] sel);
        {cmp_req, i2cm_req, i2cs_req} <= sel;
        @(posedge mclk);
        {cmp_req, i2cm_req, i2cs_req} <= 3'h0;
        @(posedge mclk);
    endtask

    // Reset values, then all-ones writes to see which bits stick; last offset is unmapped
    task automatic t_regs();
        logic [7:0] offs [8] = '{IPEC_OFF_CTL, IPEC_OFF_FLAG, IPEC_OFF_PRIO_A,
            IPEC_OFF_PRIO_B, IPEC_OFF_PRIO_C, IPEC_OFF_EVT_STAT, IPEC_OFF_EVT_MASK, 8'h1C};
        logic [15:0] rst [8] = '{16'h0000, 16'h0000, 16'h4444, 16'h0444, 16'h4444,
            16'h0000, 16'h0000, 16'h0000};
        logic [15:0] ones [8] = '{16'h8007, 16'h0007, 16'h7777, 16'h0777, 16'h7777,
            16'h0000, 16'h003F, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            rd("reset value", offs[i], rst[i]);
        end
        check("alt select at reset", {31'h0, alt_sel}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(offs[i], 16'hFFFF);
        end
        for (int i = 0; i < 8; i++) begin
            rd("all ones readback", offs[i], ones[i]);
        end
        check("alt select set", {31'h0, alt_sel}, 32'h1);
        wr(IPEC_OFF_FLAG, 16'h0000);
    endtask

    // Status bit follows the core, and software cannot write it
    task automatic t_irq_disable_instr_active();
        irq_disable_instr_active_cmd <= 1'b1;
        wait_cyc(3);
        rd("disable status on", IPEC_OFF_CTL, 16'hC007);
        wr(IPEC_OFF_CTL, 16'h0007);
        rd("disable status kept", IPEC_OFF_CTL, 16'h4007);
        check("alt select cleared", {31'h0, alt_sel}, 32'h0);
        irq_disable_instr_active_cmd <= 1'b0;
        wait_cyc(3);
        rd("disable status off", IPEC_OFF_CTL, 16'h0007);
    endtask

    // Falling select ignores a rise, then rising select ignores a fall
    task automatic t_ext();
        ext_pin <= 3'h1;
        wait_cyc(8);
        rd("rise with falling select", IPEC_OFF_EVT_STAT, 16'h0000);
        check("no irq on ignored edge", {31'h0, irq}, 32'h0);
        ext_pin <= 3'h0;
        wait_cyc(8);
        rd("fall with falling select", IPEC_OFF_EVT_STAT, 16'h0001);
        check("irq on pin event", {31'h0, irq}, 32'h1);
        wr(IPEC_OFF_CTL, 16'h0000);
        wr(IPEC_OFF_EVT_STAT, 16'h0001);
        rd("event cleared", IPEC_OFF_EVT_STAT, 16'h0000);
        check("irq dropped", {31'h0, irq}, 32'h0);
        ext_pin <= 3'h6;
        wait_cyc(8);
        rd("rise with rising select", IPEC_OFF_EVT_STAT, 16'h0006);
        wr(IPEC_OFF_EVT_STAT, 16'h0006);
        ext_pin <= 3'h0;
        wait_cyc(8);
        rd("fall with rising select", IPEC_OFF_EVT_STAT, 16'h0000);
    endtask

    // Each source sets its own flag bit; masking gates the interrupt line only
    task automatic t_flags();
        pulse(3'h4);
        rd("comparator flag", IPEC_OFF_FLAG, 16'h0004);
        check("irq from comparator", {31'h0, irq}, 32'h1);
        pulse(3'h2);
        rd("master flag", IPEC_OFF_FLAG, 16'h0006);
        pulse(3'h1);
        rd("slave flag", IPEC_OFF_FLAG, 16'h0007);
        rd("event bits", IPEC_OFF_EVT_STAT, 16'h0038);
        wr(IPEC_OFF_FLAG, 16'h0000);
        rd("flags cleared", IPEC_OFF_FLAG, 16'h0000);
        wr(IPEC_OFF_EVT_STAT, 16'h003F);
        wr(IPEC_OFF_EVT_MASK, 16'h0000);
        pulse(3'h4);
        wait_cyc(2);
        check("masked irq", {31'h0, irq}, 32'h0);
        wr(IPEC_OFF_EVT_MASK, 16'h0020);
        wait_cyc(2);
        check("unmasked irq", {31'h0, irq}, 32'h1);
        wr(IPEC_OFF_EVT_STAT, 16'h0020);
        wait_cyc(2);
        check("irq after clear", {31'h0, irq}, 32'h0);
    endtask

    // Highest level wins, lower index breaks ties, level zero never requests
    task automatic t_prio();
        logic [15:0] pa [6] = '{16'h4444, 16'h0007, 16'h7001, 16'h0000, 16'h0120, 16'h0000};
        logic [10:0] sq [6] = '{11'h00F, 11'h00F, 11'h00F, 11'h00F, 11'h00F, 11'h001};
        logic [2:0] lv [6] = '{3'h4, 3'h7, 3'h7, 3'h0, 3'h2, 3'h0};
        logic [3:0] sr [6] = '{4'h0, 4'h0, 4'h3, 4'h0, 4'h1, 4'h0};
        for (int i = 0; i < 6; i++) begin
            wr(IPEC_OFF_PRIO_A, pa[i]);
            src_req <= sq[i];
            wait_cyc(3);
            check("request level", {29'h0, req_level}, {29'h0, lv[i]});
            check("request source", {28'h0, req_src}, {28'h0, sr[i]});
            if (lv[i] != 3'h0) begin
                check("taken vector", {27'h0, taken}, {27'h0, 1'b0, sr[i]});
            end
        end
        src_req <= 11'h000;
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cut a hang short well beyond the few hundred cycles the tests need
    initial begin
        #(20000 * 50);
        fail_count++;
        stop_test();
    end

    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ext_pin = 3'h0;
        {cmp_req, i2cm_req, i2cs_req} = 3'h0;
        src_req = 11'h000;
        irq_disable_instr_active_cmd = 1'b0;
        fail_count = 0;
        n_tests = 0;
        wait_cyc(6);
        srst <= 1'b0;
        wait_cyc(4);
        t_regs();
        t_irq_disable_instr_active();
        t_ext();
        t_flags();
        t_prio();
        stop_test();
    end
endmodule
